// ---- common/tsc_defs.svh ----
// Offsets, field positions and reset values of the tile status configuration bank
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// ==========================================================
// Register numbers
`define TSC_REG_VECTOR_BASE 8'h01
`define TSC_REG_TILE_CTRL 8'h02
`define TSC_REG_BOOT_STATUS 8'h03
`define TSC_REG_SECURITY 8'h05
`define TSC_REG_OSC_CTRL 8'h06
`define TSC_REG_OSC_CNT0 8'h07
`define TSC_REG_OSC_CNT1 8'h08
`define TSC_REG_OSC_CNT2 8'h09
`define TSC_REG_OSC_CNT3 8'h0a

// ==========================================================
// Writable masks and reset values
`define TSC_VECTOR_BASE_MASK 32'hfffc_0000
`define TSC_TILE_CTRL_MASK 32'h03ff_ff36
`define TSC_SECURITY_MASK 32'h8000_5fb1
`define TSC_OSC_CTRL_MASK 32'h0000_0003
`define TSC_VECTOR_BASE_RST 32'h0000_0000
`define TSC_TILE_CTRL_RST 32'h0000_0000
`define TSC_SECURITY_RST 32'h0000_0000
`define TSC_OSC_CTRL_RST 32'h0000_0000

// ==========================================================
// Field positions
`define TSC_VB_HI 31
`define TSC_VB_LO 16
`define TSC_SEC_LOCK_BIT 31
`define TSC_OSC_CORE_BIT 1
`define TSC_OSC_PERIPH_BIT 0
`define TSC_OSC_SETTLE_CYCLES 10

`endif

// ---- common/tsc_pkg.sv ----
// Types shared by the tile status configuration bank
package tsc_pkg;

    // ==========================================================
    // Tile feature control layout
    typedef struct packed {
        logic [5:0] rsvd31;
        logic [7:0] rgmii_tx_delay;
        logic [8:0] rgmii_div;
        logic rgmii_port_enable;
        logic [1:0] rsvd7;
        logic lp_div_dynamic;
        logic lp_div_enable;
        logic rsvd3;
        logic usb_utmi_mode;
        logic ulpi_support_en;
        logic rsvd0;
    } tsc_tile_ctrl_t;

    // ==========================================================
    // Security settings layout
    typedef struct packed {
        logic write_lock;
        logic [15:0] rsvd30;
        logic global_debug_off;
        logic rsvd13;
        logic otp_master_lock;
        logic [3:0] otp_sector_lock;
        logic otp_redundancy_on;
        logic rsvd6;
        logic otp_boot_override;
        logic pll_jtag_off;
        logic [2:0] rsvd3;
        logic jtag_tap_off;
    } tsc_security_t;

    // ==========================================================
    // Boot status inputs from the boot logic
    typedef struct packed {
        logic [7:0] processor_num;
        logic boot_override_flag;
        logic second_core_powered_flag;
        logic otp_poll_disable;
        logic boot_from_ram;
        logic boot_from_jtag;
        logic [1:0] pll_strap_value;
    } tsc_boot_status_t;

    // ==========================================================
    // Processor status access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } tsc_ps_req_t;

endpackage

// ---- src/tsc_osc_counter.sv ----
// One ring oscillator edge counter, kept across system reset
`timescale 1ns/10ps
module tsc_osc_counter
    import tsc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic por_n_i,
    input wire logic osc_tick_i,
    output logic [CNT_W-1:0] count_o
);

    // ==========================================================
    // Synchroniser, the oscillator is asynchronous to the tile clock
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic last_q;
    logic last_d;
    logic tick;

    // Shift in; a rising change counts once stages two and three agree
    always_comb begin
        sync_d = {sync_q[1:0], osc_tick_i};
        tick = (sync_q[1] == sync_q[2]) && (sync_q[2] != last_q);
        last_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : last_q;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_q <= 3'h0;
            last_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    // ==========================================================
    // Counter cleared only at power-on, system reset leaves it alone
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (tick && last_q == 1'b0) begin
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge core_clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count_o = cnt_q;

endmodule

// ---- src/tsc_regs.sv ----
// Processor status register bank of one processor tile
//
// Functional notes
// - Event target: base upper half, vector lower
// - Vector base writable 31:18, rest read-only
// - Control 25:18 sets TX data delay
// - Control 17:9 drives TX clock divider counter
// - Control bit 8 enables RGMII port
// - Control bit 4 enables low-power divider
// - Bit 5 dynamic: divide only when paused
// - Control bit 2: UTMI one, ULPI zero
// - Control bit 1 enables ULPI support
// - Boot status read-only, processor number 23:16
// - Boot status straps, boot sources, flags
// - Security register loaded from OTP word
// - Security bit 31 refuses further writes
// - Bit 12 locks all, 11:8 per-sector
// - Bits 14, 4, 0 disable debug paths
// - Bit 5 OTP boot, bit 7 redundancy
// - Four ring oscillators feed own counters
// - Control bit 1 core, bit 0 peripheral
// - Oscillators asynchronous to tile clock
// - 16-bit counts kept across system reset
// - Reached by processor status reads, writes
// - Third, fourth counts are peripheral oscillators
`timescale 1ns/10ps
`include "tsc_defs.svh"
module tsc_regs
    import tsc_pkg::*;
#(
    parameter int OSC_N = 4,
    parameter int OSC_CNT_W = 16,
    parameter int DIV_W = 9
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic por_n_i,
    input wire tsc_ps_req_t ps_req_i,
    output logic [31:0] ps_rdata_o,
    output logic ps_done_o,
    output logic ps_fail_o,
    input wire logic evt_fire_i,
    input wire logic [15:0] evt_vector_i,
    output logic [31:0] evt_target_o,
    output logic evt_target_valid_o,
    input wire tsc_boot_status_t boot_status_i,
    input wire logic otp_load_i,
    input wire logic [31:0] otp_word_i,
    input wire logic all_threads_paused_i,
    output logic rgmii_port_enable_o,
    output logic [7:0] rgmii_tx_delay_o,
    output logic rgmii_txclk_o,
    output logic lp_clkdiv_active_o,
    output logic usb_utmi_mode_o,
    output logic ulpi_support_en_o,
    output logic sec_write_locked_o,
    output logic otp_master_lock_o,
    output logic [3:0] otp_sector_lock_o,
    output logic global_debug_off_o,
    output logic pll_jtag_off_o,
    output logic jtag_tap_off_o,
    output logic otp_boot_override_o,
    output logic otp_redundancy_on_o,
    input wire logic [OSC_N-1:0] osc_tick_i,
    output logic [OSC_N-1:0] osc_run_o
);

    // ==========================================================
    // Stored registers
    logic [31:0] vbase_q;
    logic [31:0] vbase_d;
    tsc_tile_ctrl_t tctrl_q;
    tsc_tile_ctrl_t tctrl_d;
    tsc_security_t sec_q;
    tsc_security_t sec_d;
    logic [31:0] oscctl_q;
    logic [31:0] oscctl_d;

    // Access answer registers
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic done_q;
    logic done_d;
    logic fail_q;
    logic fail_d;

    // Event target registers
    logic [31:0] target_q;
    logic [31:0] target_d;
    logic target_vld_q;
    logic target_vld_d;

    // Oscillator counts
    logic [OSC_CNT_W-1:0] osc_count [OSC_N];

    // Decoded access
    logic wr_hit;
    logic rd_hit;
    logic wr_ok;
    logic [31:0] boot_word;
    logic [31:0] rd_word;

    // ==========================================================
    // Boot status word, every bit read-only
    always_comb begin
        boot_word = 32'h0000_0000;
        boot_word[23:16] = boot_status_i.processor_num;
        boot_word[8] = boot_status_i.boot_override_flag;
        boot_word[5] = boot_status_i.second_core_powered_flag;
        boot_word[4] = boot_status_i.otp_poll_disable;
        boot_word[3] = boot_status_i.boot_from_ram;
        boot_word[2] = boot_status_i.boot_from_jtag;
        boot_word[1:0] = boot_status_i.pll_strap_value;
    end

    // ==========================================================
    // Read decode; reserved bits come back as zero through the masks
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (ps_req_i.addr)
            `TSC_REG_VECTOR_BASE: begin
                rd_word = vbase_q & `TSC_VECTOR_BASE_MASK;
            end
            `TSC_REG_TILE_CTRL: begin
                rd_word = tctrl_q & `TSC_TILE_CTRL_MASK;
            end
            `TSC_REG_BOOT_STATUS: begin
                rd_word = boot_word;
            end
            `TSC_REG_SECURITY: begin
                rd_word = sec_q & `TSC_SECURITY_MASK;
            end
            `TSC_REG_OSC_CTRL: begin
                rd_word = oscctl_q & `TSC_OSC_CTRL_MASK;
            end
            `TSC_REG_OSC_CNT0: begin
                rd_word = {16'h0000, osc_count[0]};
            end
            `TSC_REG_OSC_CNT1: begin
                rd_word = {16'h0000, osc_count[1]};
            end
            `TSC_REG_OSC_CNT2: begin
                rd_word = {16'h0000, osc_count[2]};
            end
            `TSC_REG_OSC_CNT3: begin
                rd_word = {16'h0000, osc_count[3]};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Write decode; read-only numbers and a locked security word fail
    always_comb begin
        wr_hit = 1'b0;
        case (ps_req_i.addr)
            `TSC_REG_VECTOR_BASE: begin
                wr_hit = 1'b1;
            end
            `TSC_REG_TILE_CTRL: begin
                wr_hit = 1'b1;
            end
            `TSC_REG_SECURITY: begin
                wr_hit = !sec_q.write_lock;
            end
            `TSC_REG_OSC_CTRL: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
        wr_ok = ps_req_i.wr && wr_hit;
    end

    // ==========================================================
    // Register next state, write masks keep reserved bits at zero
    always_comb begin
        vbase_d = vbase_q;
        tctrl_d = tctrl_q;
        sec_d = sec_q;
        oscctl_d = oscctl_q;
        if (wr_ok) begin
            case (ps_req_i.addr)
                `TSC_REG_VECTOR_BASE: begin
                    vbase_d = ps_req_i.wdata & `TSC_VECTOR_BASE_MASK;
                end
                `TSC_REG_TILE_CTRL: begin
                    tctrl_d = ps_req_i.wdata & `TSC_TILE_CTRL_MASK;
                end
                `TSC_REG_SECURITY: begin
                    sec_d = ps_req_i.wdata & `TSC_SECURITY_MASK;
                end
                `TSC_REG_OSC_CTRL: begin
                    oscctl_d = ps_req_i.wdata & `TSC_OSC_CTRL_MASK;
                end
                default: begin
                    vbase_d = vbase_q;
                end
            endcase
        end
        // OTP copy is loaded by hardware and wins over a software write
        if (otp_load_i) begin
            sec_d = otp_word_i & `TSC_SECURITY_MASK;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vbase_q <= `TSC_VECTOR_BASE_RST;
            tctrl_q <= `TSC_TILE_CTRL_RST;
            sec_q <= `TSC_SECURITY_RST;
            oscctl_q <= `TSC_OSC_CTRL_RST;
        end else begin
            vbase_q <= vbase_d;
            tctrl_q <= tctrl_d;
            sec_q <= sec_d;
            oscctl_q <= oscctl_d;
        end
    end

    // ==========================================================
    // Answer a cycle later; read with write counts as a write
    always_comb begin
        done_d = ps_req_i.rd || ps_req_i.wr;
        fail_d = (ps_req_i.wr && !wr_hit) || (ps_req_i.rd && !ps_req_i.wr && !rd_hit);
        rdata_d = rdata_q;
        if (ps_req_i.rd) begin
            rdata_d = rd_word;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0000_0000;
            done_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            done_q <= done_d;
            fail_q <= fail_d;
        end
    end

    // ==========================================================
    // Event branch target, upper half from base, lower from the vector
    always_comb begin
        target_vld_d = evt_fire_i;
        target_d = target_q;
        if (evt_fire_i) begin
            target_d = {vbase_q[`TSC_VB_HI:`TSC_VB_LO], evt_vector_i};
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            target_q <= 32'h0000_0000;
            target_vld_q <= 1'b0;
        end else begin
            target_q <= target_d;
            target_vld_q <= target_vld_d;
        end
    end

    // ==========================================================
    // Tile feature outputs
    assign rgmii_port_enable_o = tctrl_q.rgmii_port_enable;
    assign rgmii_tx_delay_o = tctrl_q.rgmii_tx_delay;
    assign usb_utmi_mode_o = tctrl_q.usb_utmi_mode;
    assign ulpi_support_en_o = tctrl_q.ulpi_support_en;
    // Dynamic mode only divides while every active thread waits
    assign lp_clkdiv_active_o = tctrl_q.lp_div_enable
        && (!tctrl_q.lp_div_dynamic || all_threads_paused_i);

    // Divider field already holds ratio minus one, used as is
    tsc_rgmii_clkgen #(
        .DIV_W(DIV_W)
    ) u_rgmii_clkgen (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(tctrl_q.rgmii_port_enable),
        .div_i(tctrl_q.rgmii_div),
        .txclk_o(rgmii_txclk_o)
    );

    // ==========================================================
    // Security outputs
    assign sec_write_locked_o = sec_q.write_lock;
    assign otp_master_lock_o = sec_q.otp_master_lock;
    assign otp_sector_lock_o = sec_q.otp_sector_lock;
    assign global_debug_off_o = sec_q.global_debug_off;
    assign pll_jtag_off_o = sec_q.pll_jtag_off;
    assign jtag_tap_off_o = sec_q.jtag_tap_off;
    assign otp_boot_override_o = sec_q.otp_boot_override;
    assign otp_redundancy_on_o = sec_q.otp_redundancy_on;

    // ==========================================================
    // Ring oscillators: first half core, second half peripheral.
    // Counts are not frozen on read, software waits for them to settle
    genvar gi;
    generate
        for (gi = 0; gi < OSC_N; gi++) begin : g_osc
            assign osc_run_o[gi] = (gi < OSC_N / 2) ? oscctl_q[`TSC_OSC_CORE_BIT]
                : oscctl_q[`TSC_OSC_PERIPH_BIT];
            tsc_osc_counter #(
                .CNT_W(OSC_CNT_W)
            ) u_osc (
                .core_clk_i(core_clk_i),
                .reset_n_i(reset_n_i),
                .por_n_i(por_n_i),
                .osc_tick_i(osc_tick_i[gi]),
                .count_o(osc_count[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Answer outputs
    assign ps_rdata_o = rdata_q;
    assign ps_done_o = done_q;
    assign ps_fail_o = fail_q;
    assign evt_target_o = target_q;
    assign evt_target_valid_o = target_vld_q;

endmodule

// ---- src/tsc_rgmii_clkgen.sv ----
// Divided transmit clock for the RGMII port
`timescale 1ns/10ps
module tsc_rgmii_clkgen
    import tsc_pkg::*;
#(
    parameter int DIV_W = 9
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic txclk_o
);

    // ==========================================================
    // Counter wraps at the divide value, clock edges at value and value>>1
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic clk_q;
    logic clk_d;

    always_comb begin
        cnt_d = '0;
        clk_d = 1'b0;
        if (enable_i) begin
            cnt_d = (cnt_q >= div_i) ? '0 : cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
            clk_d = clk_q;
            // Rise wins when both match, so divide-by-one holds high
            if (cnt_q == div_i) begin
                clk_d = 1'b1;
            end else if (cnt_q == (div_i >> 1)) begin
                clk_d = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign txclk_o = clk_q;

endmodule

// ---- test/test_tsc_regs.sv ----
// Self-checking bench for the tile status configuration bank
`timescale 1ns/10ps
`include "tsc_defs.svh"
module test_tsc_regs;
    import tsc_pkg::*;
    logic core_clk_i, reset_n_i, por_n_i, ps_done_o, ps_fail_o, evt_fire_i, evt_target_valid_o;
    logic otp_load_i, all_threads_paused_i, rgmii_port_enable_o, rgmii_txclk_o;
    logic lp_clkdiv_active_o, usb_utmi_mode_o, ulpi_support_en_o, sec_write_locked_o;
    logic otp_master_lock_o, global_debug_off_o, pll_jtag_off_o, jtag_tap_off_o;
    logic otp_boot_override_o, otp_redundancy_on_o;
    logic [31:0] ps_rdata_o, evt_target_o, otp_word_i;
    logic [15:0] evt_vector_i;
    logic [7:0] rgmii_tx_delay_o;
    logic [3:0] otp_sector_lock_o, osc_tick_i, osc_run_o;
    tsc_ps_req_t ps_req_i;
    tsc_boot_status_t boot_status_i;
    int error_cnt = 0;
    int check_count = 0;
    int edges[$];
    logic prev;
    logic [7:0] rw_addr [4] = '{8'h01, 8'h02, 8'h06, 8'h05};
    logic [31:0] rw_mask [4] = '{`TSC_VECTOR_BASE_MASK, `TSC_TILE_CTRL_MASK,
                                 `TSC_OSC_CTRL_MASK, `TSC_SECURITY_MASK};

    tsc_regs i_tsc_regs (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i),
        .ps_req_i(ps_req_i), .ps_rdata_o(ps_rdata_o), .ps_done_o(ps_done_o),
        .ps_fail_o(ps_fail_o), .evt_fire_i(evt_fire_i), .evt_vector_i(evt_vector_i),
        .evt_target_o(evt_target_o), .evt_target_valid_o(evt_target_valid_o),
        .boot_status_i(boot_status_i), .otp_load_i(otp_load_i), .otp_word_i(otp_word_i),
        .all_threads_paused_i(all_threads_paused_i), .rgmii_port_enable_o(rgmii_port_enable_o),
        .rgmii_tx_delay_o(rgmii_tx_delay_o), .rgmii_txclk_o(rgmii_txclk_o),
        .lp_clkdiv_active_o(lp_clkdiv_active_o), .usb_utmi_mode_o(usb_utmi_mode_o),
        .ulpi_support_en_o(ulpi_support_en_o), .sec_write_locked_o(sec_write_locked_o),
        .otp_master_lock_o(otp_master_lock_o), .otp_sector_lock_o(otp_sector_lock_o),
        .global_debug_off_o(global_debug_off_o), .pll_jtag_off_o(pll_jtag_off_o),
        .jtag_tap_off_o(jtag_tap_off_o), .otp_boot_override_o(otp_boot_override_o),
        .otp_redundancy_on_o(otp_redundancy_on_o), .osc_tick_i(osc_tick_i),
        .osc_run_o(osc_run_o)
    );

    // ==========================================================
    // Clock, 100 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // ==========================================================
    // Checking and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle pulse, answer sampled 1 ns after its edge
    task automatic access(input logic rd, input logic wr, input logic [7:0] a,
                          input logic [31:0] d, input logic f);
        @(posedge core_clk_i);
        ps_req_i <= '{rd: rd, wr: wr, addr: a, wdata: d};
        @(posedge core_clk_i);
        ps_req_i <= '0;
        #1;
        check({ps_done_o, ps_fail_o}, {1'b1, f});
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic f);
        access(1'b0, 1'b1, a, d, f);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input logic f);
        access(1'b1, 1'b0, a, 32'h0, f);
        if (!f) check(ps_rdata_o, exp);
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog, the tests need under a thousand cycles
    initial begin
        #(3000 * 100);
        error_cnt++;
        end_of_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        ps_req_i = '0;
        evt_fire_i = 1'b0;
        evt_vector_i = 16'h0;
        otp_load_i = 1'b0;
        otp_word_i = 32'h0;
        all_threads_paused_i = 1'b0;
        osc_tick_i = 4'h0;
        boot_status_i = '{processor_num: 8'h5a, boot_override_flag: 1'b1,
                          second_core_powered_flag: 1'b0, otp_poll_disable: 1'b1,
                          boot_from_ram: 1'b0, boot_from_jtag: 1'b1, pll_strap_value: 2'h2};
        reset_n_i = 1'b0;
        por_n_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        por_n_i <= 1'b1;
        // Reset values, boot status, refused places
        for (int i = 0; i < 4; i++) rd_reg(rw_addr[i], 32'h0, 1'b0);
        for (int i = 7; i < 11; i++) rd_reg(8'(i), 32'h0, 1'b0);
        rd_reg(8'h03, 32'h005a_0116, 1'b0);
        wr_reg(8'h03, 32'hffff_ffff, 1'b1);
        rd_reg(8'h03, 32'h005a_0116, 1'b0);
        rd_reg(8'h04, 32'h0, 1'b1);
        wr_reg(8'h04, 32'h0, 1'b1);
        $display("test reset done");
        // All ones everywhere, security last since it locks
        for (int i = 0; i < 4; i++) begin
            wr_reg(rw_addr[i], 32'hffff_ffff, 1'b0);
            rd_reg(rw_addr[i], rw_mask[i], 1'b0);
        end
        check({rgmii_port_enable_o, rgmii_tx_delay_o, usb_utmi_mode_o, ulpi_support_en_o},
              32'h7ff);
        check(osc_run_o, 4'hf);
        check({sec_write_locked_o, otp_master_lock_o, otp_sector_lock_o, global_debug_off_o,
               pll_jtag_off_o, jtag_tap_off_o, otp_boot_override_o, otp_redundancy_on_o},
              32'h7ff);
        wr_reg(8'h05, 32'h0, 1'b1);
        rd_reg(8'h05, `TSC_SECURITY_MASK, 1'b0);
        @(posedge core_clk_i);
        otp_load_i <= 1'b1;
        otp_word_i <= 32'h11;
        @(posedge core_clk_i);
        otp_load_i <= 1'b0;
        rd_reg(8'h05, 32'h11, 1'b0);
        check({pll_jtag_off_o, jtag_tap_off_o, otp_boot_override_o}, 32'h6);
        wr_reg(8'h05, 32'h10a0, 1'b0);
        rd_reg(8'h05, 32'h10a0, 1'b0);
        check({otp_master_lock_o, otp_boot_override_o, otp_redundancy_on_o}, 32'h7);
        $display("test access done");
        // Event target from base and vector
        wr_reg(8'h01, 32'habcd_ffff, 1'b0);
        @(posedge core_clk_i);
        evt_fire_i <= 1'b1;
        evt_vector_i <= 16'h1234;
        @(posedge core_clk_i);
        evt_fire_i <= 1'b0;
        #1;
        check(evt_target_o, 32'habcc_1234);
        check(evt_target_valid_o, 1'b1);
        $display("test event target done");
        // Low-power divider, every mode and pause
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'h02, {26'h0, 2'(i >> 1), 4'h0}, 1'b0);
            @(posedge core_clk_i);
            all_threads_paused_i <= i[0];
            @(posedge core_clk_i);
            #1;
            check(lp_clkdiv_active_o, i[1] && (!i[2] || i[0]));
        end
        $display("test divider done");
        // Transmit clock period with divider three is four cycles
        wr_reg(8'h02, 32'h0000_0706, 1'b0);
        check({usb_utmi_mode_o, ulpi_support_en_o}, 32'h3);
        prev = 1'b1;
        for (int c = 0; c < 40; c++) begin
            @(posedge core_clk_i);
            #1;
            if (rgmii_txclk_o && !prev) edges.push_back(c);
            prev = rgmii_txclk_o;
        end
        check(32'(edges.size() > 2 ? edges[2] - edges[1] : 0), 4);
        $display("test transmit clock done");
        // Run bits, counts per oscillator, kept over reset
        wr_reg(8'h06, 32'h2, 1'b0);
        check(osc_run_o, 4'h3);
        wr_reg(8'h06, 32'h1, 1'b0);
        check(osc_run_o, 4'hc);
        for (int t = 0; t < 4; t++) begin
            @(posedge core_clk_i);
            osc_tick_i <= 4'hf << t;
            repeat (4) @(posedge core_clk_i);
            osc_tick_i <= 4'h0;
            repeat (4) @(posedge core_clk_i);
        end
        wr_reg(8'h06, 32'h0, 1'b0);
        repeat (10) @(posedge core_clk_i);
        for (int i = 0; i < 4; i++) rd_reg(8'(7 + i), 32'(i + 1), 1'b0);
        @(posedge core_clk_i) reset_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) rd_reg(8'(7 + i), 32'(i + 1), 1'b0);
        rd_reg(8'h02, 32'h0, 1'b0);
        $display("test oscillators done");
        end_of_test();
    end
endmodule

// ---- test/tsc_regs_checker.sv ----
// Concurrent checks on the ports of the tile status configuration bank
`timescale 1ns/10ps
module tsc_regs_checker
    import tsc_pkg::*;
#(
    parameter int OSC_N = 4
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire tsc_ps_req_t ps_req_i,
    input wire logic [31:0] ps_rdata_o,
    input wire logic ps_done_o,
    input wire logic ps_fail_o,
    input wire logic evt_fire_i,
    input wire logic [15:0] evt_vector_i,
    input wire logic [31:0] evt_target_o,
    input wire logic evt_target_valid_o,
    input wire logic otp_load_i,
    input wire logic [31:0] otp_word_i,
    input wire logic sec_write_locked_o,
    input wire logic jtag_tap_off_o,
    input wire logic [OSC_N-1:0] osc_run_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // ==========================================================
    // Request sequences
    sequence s_req;
        ps_req_i.rd || ps_req_i.wr;
    endsequence
    sequence s_ro_wr;
        ps_req_i.wr && ps_req_i.addr == 8'h03;
    endsequence
    // A same-cycle OTP load wins, so it is excluded
    sequence s_locked_wr;
        sec_write_locked_o && ps_req_i.wr && ps_req_i.addr == 8'h05 && !otp_load_i;
    endsequence

    // ==========================================================
    // Properties
    req_answer_a: assert property (s_req |=> ps_done_o)
        else $error("no answer");
    idle_quiet_a: assert property (!ps_req_i.rd && !ps_req_i.wr
        |=> !ps_done_o && !ps_fail_o) else $error("stray answer");
    ro_refuse_a: assert property (s_ro_wr |=> ps_fail_o)
        else $error("boot write taken");
    lock_refuse_a: assert property (s_locked_wr |=> ps_fail_o && sec_write_locked_o)
        else $error("locked write taken");
    unmapped_read_a: assert property (ps_req_i.rd && ps_req_i.addr == 8'h04 |=> ps_fail_o)
        else $error("unmapped read taken");
    evt_vector_a: assert property (evt_fire_i |=> evt_target_valid_o
        && evt_target_o[15:0] == $past(evt_vector_i)) else $error("bad target low half");
    evt_base_a: assert property (evt_target_valid_o |-> evt_target_o[17:16] == 2'b00)
        else $error("bad target bits");
    otp_copy_a: assert property (otp_load_i |=> jtag_tap_off_o == $past(otp_word_i[0])
        && sec_write_locked_o == $past(otp_word_i[31])) else $error("OTP word not copied");
    rdata_hold_a: assert property (!ps_req_i.rd |=> $stable(ps_rdata_o))
        else $error("read data moved");
    run_pair_a: assert property (osc_run_o[0] == osc_run_o[1]
        && osc_run_o[2] == osc_run_o[3]) else $error("run pairs differ");
endmodule

bind tsc_regs tsc_regs_checker #(.OSC_N(OSC_N)) i_tsc_regs_checker (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ps_req_i(ps_req_i),
    .ps_rdata_o(ps_rdata_o), .ps_done_o(ps_done_o), .ps_fail_o(ps_fail_o),
    .evt_fire_i(evt_fire_i), .evt_vector_i(evt_vector_i), .evt_target_o(evt_target_o),
    .evt_target_valid_o(evt_target_valid_o), .otp_load_i(otp_load_i),
    .otp_word_i(otp_word_i), .sec_write_locked_o(sec_write_locked_o),
    .jtag_tap_off_o(jtag_tap_off_o), .osc_run_o(osc_run_o)
);
